// [core/sdi_mon_pkg.sv]
// constants, field layout and carrier types of the receive status monitor
// assumes all status inputs come from logic on the receive user clock
package sdi_mon_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int ERR_CNT_W = 16;
  localparam int FAIL_CODE_W = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PAYLOAD = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ERRCNT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'hc;

  // status word fields
  localparam int ST_LOCKED = 0;
  localparam int ST_TYPE_LO = 1;
  localparam int ST_DONE = 3;
  localparam int ST_FAIL = 4;
  localparam int ST_ERR = 5;
  localparam int ST_PID_VALID = 6;
  localparam int ST_CODE_LO = 8;

  // control word fields, write one to act
  localparam int CTL_ERR_CLR = 0;
  localparam int CTL_RX_RST = 1;

  localparam logic [ERR_CNT_W-1:0] ERR_CNT_RST = 16'h0000;
  localparam logic [ERR_CNT_W-1:0] ERR_CNT_MAX = 16'hffff;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_HD = 2'h0,
    MODE_SD = 2'h1,
    MODE_3G = 2'h2
  } rx_mode_type;

  typedef enum logic [1:0] {
    TYPE_SD = 2'h0,
    TYPE_HD = 2'h1,
    TYPE_3GA = 2'h2,
    TYPE_3GB = 2'h3
  } sig_type_type;

  typedef struct packed {
    logic locked;
    rx_mode_type mode;
    logic level_b;
    logic change_busy;
    logic change_fail;
    logic [FAIL_CODE_W-1:0] fail_code;
  } rx_status_type;

  typedef struct packed {
    logic crc_err;
    logic edh_err;
    logic relock;
  } rx_events_type;

  typedef struct packed {
    logic valid;
    logic [31:0] bytes;
  } pid_type;

endpackage

// [core/err_account.sv]
// sticky error flag and saturating error counter
// assumes error and relock inputs are one-cycle pulses on aclk
`timescale 1ns/1ps
module err_account (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sd_mode,
  input wire sdi_mon_pkg::rx_events_type events,
  input wire logic clear_cmd,
  output logic err_flag,
  output logic [sdi_mon_pkg::ERR_CNT_W-1:0] err_count
);
  import sdi_mon_pkg::*;

  logic flag_q, flag_d;
  logic [ERR_CNT_W-1:0] cnt_q, cnt_d;
  logic hit;

  always_comb begin
    // sd counts edh errors, hd and 3g count line checksum errors
    hit = sd_mode ? events.edh_err : events.crc_err;
    flag_d = flag_q;
    if (clear_cmd) begin
      flag_d = 1'b0;
    end
    if (events.crc_err || events.edh_err) begin
      flag_d = 1'b1;
    end
    cnt_d = cnt_q;
    if (clear_cmd || events.relock) begin
      cnt_d = ERR_CNT_RST;
    end
    if (hit) begin
      // an error in the clearing cycle counts from zero
      if (clear_cmd || events.relock) begin
        cnt_d = ERR_CNT_RST + 16'h0001;
      end else if (cnt_q != ERR_CNT_MAX) begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
      cnt_q <= ERR_CNT_RST;
    end else begin
      flag_q <= flag_d;
      cnt_q <= cnt_d;
    end
  end

  assign err_flag = flag_q;
  assign err_count = cnt_q;
endmodule

// [core/sdi_rx_status_monitor.sv]
// receive status monitor with an axi4-lite register slave
// assumes datapath status, events and payload id share aclk; no synchronisers
`timescale 1ns/1ps
module sdi_rx_status_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sdi_mon_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sdi_mon_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sdi_mon_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [sdi_mon_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sdi_mon_pkg::rx_status_type rx_status,
  input wire sdi_mon_pkg::rx_events_type rx_events,
  input wire sdi_mon_pkg::pid_type rx_pid,
  output logic rx_section_reset,
  output logic locked,
  output sdi_mon_pkg::sig_type_type sig_type,
  output logic change_done,
  output logic change_fail,
  output logic [sdi_mon_pkg::FAIL_CODE_W-1:0] fail_code,
  output logic err_flag,
  output logic [sdi_mon_pkg::ERR_CNT_W-1:0] err_count
);
  import sdi_mon_pkg::*;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_type;

  function automatic sig_type_type type_of(input rx_mode_type mode, input logic level_b);
    sig_type_type t;
    t = TYPE_HD;
    if (mode == MODE_SD) begin
      t = TYPE_SD;
    end else if (mode == MODE_3G) begin
      // level b reports TYPE_3GB, level a reports TYPE_3GA
      t = level_b ? TYPE_3GB : TYPE_3GA;
    end
    return t;
  endfunction

  // ---- registered status view
  rx_status_type st_q, st_d;
  pid_type pid_q, pid_d;

  always_comb begin
    st_d = rx_status;
    pid_d = rx_pid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      pid_q <= '0;
    end else begin
      st_q <= st_d;
      pid_q <= pid_d;
    end
  end

  assign locked = st_q.locked;
  assign sig_type = type_of(st_q.mode, st_q.level_b);
  // done reads low while out of reset only when a change is running
  assign change_done = !st_q.change_busy;
  assign change_fail = st_q.change_fail;
  assign fail_code = st_q.change_fail ? st_q.fail_code : '0;

  // ---- write channel
  wr_state_type wr_q, wr_d;
  logic aw_got_q, aw_got_d;
  logic w_got_q, w_got_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic [1:0] bresp_q, bresp_d;
  logic clr_q, clr_d;
  logic rst_q, rst_d;
  logic do_write;
  logic [ADDR_W-1:0] wa;
  logic [DATA_W-1:0] wd;
  logic ws0;

  assign s_axi_awready = (wr_q == WR_IDLE) && !aw_got_q;
  assign s_axi_wready = (wr_q == WR_IDLE) && !w_got_q;

  always_comb begin
    wr_d = wr_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bresp_d = bresp_q;
    clr_d = 1'b0;
    rst_d = 1'b0;
    wa = aw_got_q ? awaddr_q : s_axi_awaddr;
    wd = w_got_q ? wdata_q : s_axi_wdata;
    ws0 = w_got_q ? wstrb0_q : s_axi_wstrb[0];
    do_write = 1'b0;
    unique case (wr_q)
      WR_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_got_d = 1'b1;
          awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_got_d = 1'b1;
          wdata_d = s_axi_wdata;
          wstrb0_d = s_axi_wstrb[0];
        end
        do_write = aw_got_d && w_got_d;
        if (do_write) begin
          aw_got_d = 1'b0;
          w_got_d = 1'b0;
          wr_d = WR_RESP;
          bresp_d = RESP_SLVERR;
          if ({wa[ADDR_W-1:2], 2'b00} == OFS_CONTROL) begin
            bresp_d = RESP_OKAY;
            clr_d = ws0 && wd[CTL_ERR_CLR];
            rst_d = ws0 && wd[CTL_RX_RST];
          end else if ({wa[ADDR_W-1:2], 2'b00} == OFS_STATUS
              || {wa[ADDR_W-1:2], 2'b00} == OFS_PAYLOAD
              || {wa[ADDR_W-1:2], 2'b00} == OFS_ERRCNT) begin
            // read-only words ignore writes
            bresp_d = RESP_OKAY;
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          wr_d = WR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= WR_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      clr_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bresp_q <= bresp_d;
      clr_q <= clr_d;
      rst_q <= rst_d;
    end
  end

  assign s_axi_bvalid = (wr_q == WR_RESP);
  assign s_axi_bresp = bresp_q;
  // one-cycle pulse toward the receive section of the transceiver only
  assign rx_section_reset = rst_q;

  // ---- error accounting
  err_account u_err (
    .aclk(aclk),
    .aresetn(aresetn),
    .sd_mode(rx_status.mode == MODE_SD),
    .events(rx_events),
    .clear_cmd(clr_q),
    .err_flag(err_flag),
    .err_count(err_count)
  );

  // ---- read channel
  logic rvalid_q, rvalid_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [DATA_W-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[ST_LOCKED] = locked;
    status_word[ST_TYPE_LO +: 2] = sig_type;
    status_word[ST_DONE] = change_done;
    status_word[ST_FAIL] = change_fail;
    status_word[ST_ERR] = err_flag;
    status_word[ST_PID_VALID] = pid_q.valid;
    status_word[ST_CODE_LO +: FAIL_CODE_W] = fail_code;
  end

  assign s_axi_arready = !rvalid_q;

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
        OFS_STATUS: rdata_d = status_word;
        OFS_PAYLOAD: rdata_d = pid_q.bytes;
        OFS_ERRCNT: rdata_d = {{(DATA_W-ERR_CNT_W){1'b0}}, err_count};
        OFS_CONTROL: rdata_d = RDATA_RST;
        default: begin
          rdata_d = RDATA_RST;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= RDATA_RST;
      rresp_q <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

// [verif/sdi_rx_status_monitor_sva.sv]
// port assertions for the receive status monitor
// assumes a bind into sdi_rx_status_monitor, one clock aclk
`timescale 1ns/1ps
module sdi_mon_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire sdi_mon_pkg::rx_status_type rx_status,
  input wire sdi_mon_pkg::rx_events_type rx_events,
  input wire logic rx_section_reset,
  input wire logic locked,
  input wire sdi_mon_pkg::sig_type_type sig_type,
  input wire logic change_done,
  input wire logic change_fail,
  input wire logic [sdi_mon_pkg::FAIL_CODE_W-1:0] fail_code,
  input wire logic err_flag,
  input wire logic [sdi_mon_pkg::ERR_CNT_W-1:0] err_count
);
  import sdi_mon_pkg::*;
  logic hit;
  sig_type_type want;
  assign hit = (rx_status.mode == MODE_SD) ? rx_events.edh_err : rx_events.crc_err;
  always_comb begin
    want = TYPE_HD;
    if (rx_status.mode == MODE_SD) want = TYPE_SD;
    if (rx_status.mode == MODE_3G) want = rx_status.level_b ? TYPE_3GB : TYPE_3GA;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rst_pulse;
    rx_section_reset ##1 !rx_section_reset;
  endsequence
  a_locked_follow: assert property ($past(aresetn) |->
    locked == $past(rx_status.locked)) else $error("locked lags status");
  a_type_map: assert property ($past(aresetn) |-> sig_type == $past(want))
    else $error("wrong signal type");
  a_done_busy: assert property ($past(aresetn) |->
    change_done == !$past(rx_status.change_busy)) else $error("done wrong");
  a_fail_code: assert property ($past(aresetn) |-> change_fail == $past(rx_status.change_fail)
    && fail_code == ($past(rx_status.change_fail) ? $past(rx_status.fail_code) : 4'h0))
    else $error("fail code wrong");
  a_err_set: assert property (rx_events.crc_err || rx_events.edh_err |=> err_flag)
    else $error("flag not set");
  a_err_hold: assert property (err_flag && !s_axi_bvalid |=> err_flag)
    else $error("flag dropped");
  a_count_step: assert property (!s_axi_bvalid && !rx_events.relock &&
    err_count != ERR_CNT_MAX |=> err_count == $past(err_count) + ERR_CNT_W'($past(hit)))
    else $error("count step wrong");
  a_count_sat: assert property (err_count == ERR_CNT_MAX && !rx_events.relock &&
    !s_axi_bvalid |=> err_count == ERR_CNT_MAX) else $error("count wrapped");
  a_relock_zero: assert property (rx_events.relock |=>
    err_count == ERR_CNT_W'($past(hit))) else $error("relock no clear");
  a_rst_pulse: assert property (rx_section_reset |-> s_axi_bvalid ##0 rst_pulse)
    else $error("reset pulse wrong");
endmodule

bind sdi_rx_status_monitor sdi_mon_checker i_chk (.*);

// [verif/rx_datapath_model.sv]
// receive datapath model: passes commanded status and events
// assumes a receive reset makes it busy for four cycles
`timescale 1ns/1ps
module rx_datapath_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_section_reset,
  input wire sdi_mon_pkg::rx_status_type st_cmd,
  input wire sdi_mon_pkg::rx_events_type ev_cmd,
  input wire sdi_mon_pkg::pid_type pid_cmd,
  output sdi_mon_pkg::rx_status_type rx_status,
  output sdi_mon_pkg::rx_events_type rx_events,
  output sdi_mon_pkg::pid_type rx_pid
);
  import sdi_mon_pkg::*;
  logic [2:0] busy_q, busy_d;
  logic ce_q;
  always_comb begin
    busy_d = rx_section_reset ? 3'h4 : (busy_q != 3'h0) ? busy_q - 3'h1 : 3'h0;
    rx_status = st_cmd;
    rx_status.change_busy = st_cmd.change_busy | (busy_q != 3'h0);
    rx_status.locked = st_cmd.locked & (busy_q == 3'h0);
    rx_events = ev_cmd;
  end
  always_ff @(posedge aclk) begin
    busy_q <= aresetn ? busy_d : 3'h0;
    ce_q <= aresetn ? !ce_q : 1'b0;
    // sd words only count on the receive clock enable
    if (!aresetn) begin
      rx_pid <= '0;
    end else if (st_cmd.mode != MODE_SD || ce_q) begin
      rx_pid <= pid_cmd;
    end
  end
endmodule

// [verif/sdi_rx_status_monitor_test.sv]
// self-checking bench for the receive status monitor
// assumes the datapath model on the status side
`timescale 1ns/1ps
module sdi_rx_status_monitor_test;
  import sdi_mon_pkg::*;
  localparam rx_events_type CRC = 3'h4, EDH = 3'h2, RLK = 3'h1;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic rx_section_reset, locked, change_done, change_fail, err_flag;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, fail_code;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] err_count;
  rx_status_type rx_status, st_cmd;
  rx_events_type rx_events, ev_cmd;
  pid_type rx_pid, pid_cmd;
  sig_type_type sig_type;
  int err_total, num_checks, cyc, rst_seen;
  sdi_rx_status_monitor i_dut (.*);
  rx_datapath_model i_dp (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // bready and rready stay high, so the answer is taken when first seen
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wstrb <= s;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    chk(s_axi_bresp, RESP_OKAY);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, RESP_OKAY);
  endtask
  task automatic ev(input rx_events_type e, input int n);
    @(posedge aclk);
    ev_cmd <= e;
    repeat (n) @(posedge aclk);
    ev_cmd <= '0;
    #1;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (rx_section_reset) rst_seen <= rst_seen + 1;
    if (cyc == 70000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cyc} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, err_total, num_checks, rst_seen} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    {st_cmd, ev_cmd, pid_cmd} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      @(posedge aclk);
      st_cmd <= {1'b1, t == 0 ? MODE_SD : t == 1 ? MODE_HD : MODE_3G, t == 3, 6'h00};
      repeat (2) @(posedge aclk);
      #1;
      chk(sig_type, t);
      chk(locked, 1'b1);
    end
    rd(4'h0, 32'h0000_000f);
    pid_cmd <= '{valid: 1'b1, bytes: 32'h1234_5678};
    repeat (2) @(posedge aclk);
    rd(4'h4, 32'h1234_5678);
    rd(4'h0, 32'h0000_004f);
    st_cmd <= {1'b1, MODE_HD, 7'h00};
    ev(CRC, 1);
    chk(err_flag, 1'b1);
    ev(EDH, 1);
    chk(err_count, 16'h0001);
    @(posedge aclk);
    st_cmd <= {1'b1, MODE_SD, 7'h00};
    ev(CRC, 1);
    ev(EDH, 2);
    rd(4'h8, 32'h0000_0003);
    wr(4'hc, 32'h0000_0001);
    chk({err_flag, err_count}, 17'h0_0000);
    ev(EDH, 3);
    ev(RLK, 1);
    chk({err_flag, err_count}, 17'h1_0000);
    @(posedge aclk);
    st_cmd <= {1'b1, MODE_HD, 7'h00};
    ev(CRC, 65540);
    chk(err_count, 16'hffff);
    wr(4'hc, 32'h0000_0001, 4'he);
    wr(4'h8, 32'h0000_0001);
    chk(err_count, 16'hffff);
    wr(4'hc, 32'h0000_0002);
    @(posedge aclk);
    #1;
    chk({change_done, err_count}, 17'h0_ffff);
    repeat (8) @(posedge aclk);
    #1;
    chk(change_done, 1'b1);
    chk(rst_seen, 1);
    rd(4'hc, 32'h0000_0000);
    st_cmd <= {1'b1, MODE_HD, 3'h1, 4'h5};
    repeat (2) @(posedge aclk);
    #1;
    chk({change_fail, fail_code}, 5'h15);
    rd(4'h0, 32'h0000_057b);
    print_verdict();
  end
endmodule
